//--- core/aswm_monitor.sv
// Safing monitor top: link snooping, checks, counters, thresholds, mode control
`timescale 1ns/1ps
module aswm_monitor #(
  parameter int NUM_SLOT = 4,
  parameter int ARM_LIMIT = 4,
  parameter int CNT_W = 16
) (
  // System
  input wire logic MCLK,
  input wire logic RESET,
  // Serial link, snooped
  input wire logic SCLK,
  input wire logic [aswm_pkg::NUM_CS-1:0] CS_N,
  input wire logic MOSI,
  input wire logic MISO,
  // Analog safing sensor
  input wire logic SYNC_PULSE,
  input wire logic SELFTEST_INHIBIT_IN,
  input wire logic ADC_DONE,
  input wire logic [aswm_pkg::VAL_W-1:0] ADC_DATA,
  output logic ADC_START,
  output logic [aswm_pkg::VAL_W-1:0] ANA_DATA,
  // Host control
  input wire logic EXTRA_COMM_LINE,
  input wire logic SAFE_GO,
  input wire aswm_pkg::aswm_thr_cmd_t THR_CMD,
  output logic [aswm_pkg::VAL_W-1:0] THR_RD_DATA,
  // Status
  output aswm_pkg::aswm_mode_t MODE,
  output logic [CNT_W-1:0] DV_COUNT,
  output logic [CNT_W-1:0] INCIDENTS,
  output logic ORDER_ERR,
  output logic RANGE_ERR,
  // Arming
  output logic ARM_EN,
  output logic ARM_EN_N
);
  import aswm_pkg::*;

  localparam int SW = (NUM_SLOT > 1) ? $clog2(NUM_SLOT) : 1;

  // -------------------------------------------------------------
  // Parameter checks
  // -------------------------------------------------------------
  if (NUM_SLOT < 2 || NUM_SLOT > 7 || (NUM_SLOT & (NUM_SLOT - 1)) != 0) begin : g_bad_slot
    $error("NUM_SLOT must be 2 or 4");
  end
  if (ARM_LIMIT < 1 || ARM_LIMIT >= (1 << CNT_W)) begin : g_bad_limit
    $error("ARM_LIMIT out of counter range");
  end

  // -------------------------------------------------------------
  // Link capture and crossings
  // -------------------------------------------------------------
  aswm_frame_t frame;
  logic frame_tgl;
  logic tgl_s;
  logic tgl_d;
  logic sync_s;
  logic sync_d;
  logic inhibit_s;
  logic ecl_s;
  logic safe_go_s;
  logic new_frame;

  aswm_snoop u_snoop (
    .SCLK(SCLK),
    .RESET(RESET),
    .CS_N(CS_N),
    .MOSI(MOSI),
    .MISO(MISO),
    .frame(frame),
    .frame_tgl(frame_tgl)
  );

  aswm_sync #(.W(5)) u_sync (
    .MCLK(MCLK),
    .RESET(RESET),
    .d({frame_tgl, SYNC_PULSE, SELFTEST_INHIBIT_IN, EXTRA_COMM_LINE, SAFE_GO}),
    .q({tgl_s, sync_s, inhibit_s, ecl_s, safe_go_s})
  );

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      tgl_d <= 1'b0;
      sync_d <= 1'b0;
    end else begin
      tgl_d <= tgl_s;
      sync_d <= sync_s;
    end
  end

  // Frame word is stable for a whole frame after its toggle lands
  assign new_frame = tgl_s ^ tgl_d;

  // -------------------------------------------------------------
  // Decode and checks
  // -------------------------------------------------------------
  logic [ID_W-1:0] prev_req [NUM_CS];
  logic [ID_W-1:0] rep_id;
  logic [ID_W-1:0] exp_id;
  logic [ST_W-1:0] rep_st;
  logic [VAL_W-1:0] rep_val;
  logic range_ok;
  logic order_ok;
  logic spi_dv;
  logic spi_msg_ok;
  logic [SW-1:0] seq_slot;
  logic [VAL_W-1:0] thr [NUM_SLOT+1];

  assign rep_id = frame.rep[ID_LSB +: ID_W];
  assign rep_st = frame.rep[ST_LSB +: ST_W];
  assign rep_val = frame.rep[0 +: VAL_W];
  assign exp_id = prev_req[frame.cs];

  // Range and order are judged only from the captured words, never the host
  assign range_ok = rep_st == ST_OK && rep_val >= VAL_MIN && rep_val <= VAL_MAX;
  assign order_ok = rep_id == exp_id && rep_id == ID_W'(seq_slot);
  assign spi_dv = new_frame && range_ok;
  assign spi_msg_ok = spi_dv && order_ok;

  // Request seen on one select is answered in that select's next frame
  for (genvar c = 0; c < NUM_CS; c++) begin : g_cs
    always_ff @(posedge MCLK) begin
      if (RESET) begin
        prev_req[c] <= '0;
      end else if (new_frame && frame.cs == CS_W'(c)) begin
        prev_req[c] <= frame.req[ID_LSB +: ID_W];
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      ORDER_ERR <= 1'b0;
      RANGE_ERR <= 1'b0;
    end else begin
      ORDER_ERR <= new_frame && !order_ok;
      RANGE_ERR <= new_frame && !range_ok;
    end
  end

  // -------------------------------------------------------------
  // Analog safing sensor
  // -------------------------------------------------------------
  logic ana_evt;
  logic ana_dv;

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      ADC_START <= 1'b0;
    end else begin
      ADC_START <= sync_s && !sync_d;
    end
  end

  // Self-test values must never reach the compare path
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      ANA_DATA <= '0;
      ana_evt <= 1'b0;
    end else begin
      ana_evt <= ADC_DONE && !inhibit_s;
      if (ADC_DONE && !inhibit_s) begin
        ANA_DATA <= ADC_DATA;
      end
    end
  end

  assign ana_dv = ana_evt && ANA_DATA >= VAL_MIN && ANA_DATA <= VAL_MAX;

  // -------------------------------------------------------------
  // Control counters
  // -------------------------------------------------------------
  logic [CNT_W-1:0] next_dv;

  assign next_dv = DV_COUNT + CNT_W'(spi_dv) + CNT_W'(ana_dv);

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      DV_COUNT <= '0;
    end else begin
      DV_COUNT <= next_dv;
    end
  end

  // Wraps over the slot range, so the host must request slots in turn
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      seq_slot <= '0;
    end else if (spi_msg_ok) begin
      seq_slot <= seq_slot + 1'b1;
    end
  end

  // -------------------------------------------------------------
  // Threshold store, keyed access
  // -------------------------------------------------------------
  aswm_mode_t mode;
  logic unlocked;
  logic thr_fire;

  assign thr_fire = THR_CMD.we && unlocked && mode == M_DIAG &&
    THR_CMD.idx <= THR_IDX_W'(NUM_SLOT);

  // One key arms exactly one write or read; a wrong key, a write or a read relocks, idle cycles hold
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      unlocked <= 1'b0;
    end else if (THR_CMD.key) begin
      unlocked <= THR_CMD.data == THR_KEY;
    end else if (THR_CMD.we || THR_CMD.rd) begin
      unlocked <= 1'b0;
    end
  end

  for (genvar s = 0; s <= NUM_SLOT; s++) begin : g_thr
    always_ff @(posedge MCLK) begin
      if (RESET) begin
        thr[s] <= THR_RST;
      end else if (thr_fire && THR_CMD.idx == THR_IDX_W'(s)) begin
        thr[s] <= THR_CMD.data[VAL_W-1:0];
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      THR_RD_DATA <= '0;
    end else if (THR_CMD.rd && unlocked && THR_CMD.idx <= THR_IDX_W'(NUM_SLOT)) begin
      THR_RD_DATA <= thr[THR_CMD.idx];
    end
  end

  // -------------------------------------------------------------
  // Compare and incident counting
  // -------------------------------------------------------------
  logic spi_beyond;
  logic ana_beyond;
  logic counting;
  logic arm_cond;

  assign counting = mode == M_SAFE;
  assign spi_beyond = spi_msg_ok && rep_val > thr[seq_slot];
  assign ana_beyond = ana_dv && ANA_DATA > thr[NUM_SLOT];
  assign arm_cond = INCIDENTS >= CNT_W'(ARM_LIMIT);

  always_ff @(posedge MCLK) begin
    if (RESET || mode == M_DIAG) begin
      INCIDENTS <= '0;
    end else if (counting) begin
      INCIDENTS <= INCIDENTS + CNT_W'(spi_beyond) + CNT_W'(ana_beyond);
    end
  end

  // -------------------------------------------------------------
  // Safing state machine
  // -------------------------------------------------------------
  aswm_mode_t next_mode;
  logic [STARTUP_W-1:0] start_cnt;

  always_ff @(posedge MCLK) begin
    if (RESET || mode != M_START) begin
      start_cnt <= '0;
    end else begin
      start_cnt <= start_cnt + 1'b1;
    end
  end

  // Decisions use only this block's own inputs, never host software state
  always_comb begin
    next_mode = mode;
    unique case (mode)
      M_START: begin
        if (start_cnt == STARTUP_W'(STARTUP_CYC - 1)) begin
          next_mode = M_DIAG;
        end
      end
      M_DIAG: begin
        if (safe_go_s) begin
          next_mode = M_SAFE;
        end
      end
      M_SAFE: begin
        if (arm_cond) begin
          next_mode = M_ARM;
        end
      end
      M_ARM: begin
        if (ecl_s) begin
          next_mode = M_SCRAP;
        end
      end
      M_SCRAP: begin
        if (!ecl_s) begin
          next_mode = M_SAFE;
        end
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      mode <= M_START;
    end else begin
      mode <= next_mode;
    end
  end

  assign MODE = mode;

  // -------------------------------------------------------------
  // Arm-enable pair
  // -------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      ARM_EN <= 1'b0;
      ARM_EN_N <= 1'b1;
    end else begin
      ARM_EN <= next_mode == M_ARM;
      ARM_EN_N <= next_mode != M_ARM;
    end
  end

  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  sequence s_sync_rise;
    !sync_s ##1 sync_s;
  endsequence

  sequence s_arm_entry;
    (mode == M_SAFE && arm_cond) ##1 (mode == M_ARM);
  endsequence

  property p_onehot;
    @(posedge MCLK) disable iff (RESET) $onehot(mode);
  endproperty
  a_onehot: assert property (p_onehot) else $error("mode not one-hot");

  property p_arm_pair;
    @(posedge MCLK) disable iff (RESET) ARM_EN != ARM_EN_N && ARM_EN == (mode == M_ARM);
  endproperty
  a_arm_pair: assert property (p_arm_pair) else $error("arm pair wrong");

  property p_arm_entry;
    @(posedge MCLK) disable iff (RESET) (mode == M_SAFE && arm_cond) |-> s_arm_entry;
  endproperty
  a_arm_entry: assert property (p_arm_entry) else $error("arming missed");

  property p_dv_inc;
    @(posedge MCLK) disable iff (RESET) (spi_dv && !ana_dv) |=> DV_COUNT == $past(DV_COUNT) + 1'b1;
  endproperty
  a_dv_inc: assert property (p_dv_inc) else $error("valid count not advanced");

  property p_seq_inc;
    @(posedge MCLK) disable iff (RESET) spi_msg_ok |=> seq_slot == $past(seq_slot) + 1'b1;
  endproperty
  a_seq_inc: assert property (p_seq_inc) else $error("sequence not advanced");

  property p_inhibit;
    @(posedge MCLK) disable iff (RESET) inhibit_s [*2] |=> $stable(ANA_DATA);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("analog updated in self-test");

  property p_adc_start;
    @(posedge MCLK) disable iff (RESET) s_sync_rise |=> ADC_START ##1 !ADC_START;
  endproperty
  a_adc_start: assert property (p_adc_start) else $error("conversion not started");

  property p_scrap;
    @(posedge MCLK) disable iff (RESET) (mode == M_ARM && ecl_s) |=> mode == M_SCRAP && !ARM_EN;
  endproperty
  a_scrap: assert property (p_scrap) else $error("scrap not entered");

  property p_incident;
    @(posedge MCLK) disable iff (RESET)
      (counting && spi_beyond && !ana_beyond) |=> INCIDENTS == $past(INCIDENTS) + 1'b1;
  endproperty
  a_incident: assert property (p_incident) else $error("incident not counted");

  property p_reset;
    @(posedge MCLK) RESET |=> mode == M_START && !ARM_EN && ARM_EN_N && DV_COUNT == '0;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule // aswm_monitor

//--- core/aswm_snoop.sv
// Link-clock side of the serial monitor: frame capture per chip select
`timescale 1ns/1ps
module aswm_snoop
  import aswm_pkg::*;
(
  // Link
  input wire logic SCLK,
  input wire logic RESET,
  input wire logic [aswm_pkg::NUM_CS-1:0] CS_N,
  input wire logic MOSI,
  input wire logic MISO,
  // Captured frame
  output aswm_pkg::aswm_frame_t frame,
  output logic frame_tgl
);
  logic [BIT_CNT_W-1:0] bit_cnt;
  logic [FRAME_W-2:0] sh_req;
  logic [FRAME_W-2:0] sh_rep;
  logic idle;
  logic [CS_W-1:0] cs_idx;

  // Link clock stops between frames, so deselect clears the bit count
  assign idle = &CS_N;

  always_comb begin
    cs_idx = '0;
    for (int i = NUM_CS - 1; i >= 0; i--) begin
      if (!CS_N[i]) begin
        cs_idx = CS_W'(i);
      end
    end
  end

  always_ff @(posedge SCLK or posedge idle) begin
    if (idle) begin
      bit_cnt <= '0;
    end else begin
      bit_cnt <= bit_cnt + 1'b1;
    end
  end

  always_ff @(posedge SCLK) begin
    sh_req <= {sh_req[FRAME_W-3:0], MOSI};
    sh_rep <= {sh_rep[FRAME_W-3:0], MISO};
  end

  // Frame stays stable a whole frame, far longer than the crossing takes
  always_ff @(posedge SCLK or posedge RESET) begin
    if (RESET) begin
      frame <= '0;
      frame_tgl <= 1'b0;
    end else if (!idle && bit_cnt == BIT_CNT_W'(FRAME_W - 1)) begin
      frame <= '{req: {sh_req, MOSI}, rep: {sh_rep, MISO}, cs: cs_idx};
      frame_tgl <= ~frame_tgl;
    end
  end
endmodule // aswm_snoop

//--- core/aswm_sync.sv
// Two-flop level synchroniser into the system clock domain
`timescale 1ns/1ps
module aswm_sync #(
  parameter int W = 1
) (
  // System
  input wire logic MCLK,
  input wire logic RESET,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // aswm_sync

//--- shared/aswm_pkg.sv
// Shared constants and types for the airbag safing monitor
package aswm_pkg;
  // -------------------------------------------------------------
  // Link framing
  // -------------------------------------------------------------
  localparam int FRAME_W = 16;
  localparam int NUM_CS = 4;
  localparam int CS_W = 2;
  localparam int BIT_CNT_W = 4;
  localparam int ID_W = 4;
  localparam int ID_LSB = 12;
  localparam int ST_W = 2;
  localparam int ST_LSB = 10;
  localparam int VAL_W = 10;
  localparam logic [ST_W-1:0] ST_OK = 2'h1;
  localparam logic [VAL_W-1:0] VAL_MIN = 10'h010;
  localparam logic [VAL_W-1:0] VAL_MAX = 10'h3EF;
  // -------------------------------------------------------------
  // Threshold access
  // -------------------------------------------------------------
  localparam logic [FRAME_W-1:0] THR_KEY = 16'hA5C3;
  localparam logic [VAL_W-1:0] THR_RST = 10'h3FF;
  localparam int THR_IDX_W = 3;
  // -------------------------------------------------------------
  // Timing
  // -------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int STARTUP_NS = 160;
  localparam int STARTUP_CYC = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STARTUP_W = 5;
  // -------------------------------------------------------------
  // Types
  // -------------------------------------------------------------
  typedef enum logic [4:0] {
    M_START = 5'h01,
    M_DIAG = 5'h02,
    M_SAFE = 5'h04,
    M_SCRAP = 5'h08,
    M_ARM = 5'h10
  } aswm_mode_t;
  typedef struct packed {
    logic [FRAME_W-1:0] req;
    logic [FRAME_W-1:0] rep;
    logic [CS_W-1:0] cs;
  } aswm_frame_t;
  typedef struct packed {
    logic key;
    logic we;
    logic rd;
    logic [THR_IDX_W-1:0] idx;
    logic [FRAME_W-1:0] data;
  } aswm_thr_cmd_t;
endpackage

//--- verif/aswm_host.sv
// Host master model driving the snooped serial link
`timescale 1ns/1ps
module aswm_host #(
  parameter real HALF_NS = 6.0
) (
  // Link
  output logic SCLK,
  output logic [aswm_pkg::NUM_CS-1:0] CS_N,
  output logic MOSI,
  output logic MISO
);
  import aswm_pkg::*;
  initial begin
    SCLK = 1'b0;
    CS_N = '1;
    MOSI = 1'b0;
    MISO = 1'b1;
  end
  // ---------------------------------------------------------------
  // One whole frame; clock stands still low between frames
  // ---------------------------------------------------------------
  task automatic xfer(input int cs, input logic [FRAME_W-1:0] req,
                      input logic [FRAME_W-1:0] rep);
    CS_N[cs] = 1'b0;
    for (int i = FRAME_W - 1; i >= 0; i--) begin
      MOSI = req[i];
      MISO = rep[i];
      #(HALF_NS);
      SCLK = 1'b1;
      #(HALF_NS);
      SCLK = 1'b0;
    end
    #(HALF_NS);
    CS_N = '1;
    // Released lines flip so a stale bit is never mistaken for data
    MOSI = ~req[0];
    MISO = ~rep[0];
    #(HALF_NS * 2);
  endtask
endmodule // aswm_host

//--- verif/tb.sv
// Self-checking bench for the safing monitor
`timescale 1ns/1ps
module tb;
  import aswm_pkg::*;
  localparam int SLOTS = 4;
  localparam int ARM_N = 4;
  logic mclk, reset, sync_pulse, inhibit, adc_done, ecl, safe_go;
  logic sclk, mosi, miso, adc_start, order_err, range_err, arm_en, arm_en_n;
  logic [VAL_W-1:0] adc_data, ana_data, thr_rd;
  logic [NUM_CS-1:0] cs_n;
  logic [15:0] dv, inc;
  aswm_thr_cmd_t thr_cmd;
  aswm_mode_t mode;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  int n_ord = 0;
  int n_rng = 0;
  int n_start = 0;
  int slot = 0;
  int dv_exp = 0;

  aswm_host aswm_host_i (.SCLK(sclk), .CS_N(cs_n), .MOSI(mosi), .MISO(miso));
  aswm_monitor #(.NUM_SLOT(SLOTS), .ARM_LIMIT(ARM_N), .CNT_W(16)) aswm_monitor_i (
    .MCLK(mclk), .RESET(reset), .SCLK(sclk), .CS_N(cs_n), .MOSI(mosi), .MISO(miso),
    .SYNC_PULSE(sync_pulse), .SELFTEST_INHIBIT_IN(inhibit), .ADC_DONE(adc_done),
    .ADC_DATA(adc_data), .ADC_START(adc_start), .ANA_DATA(ana_data),
    .EXTRA_COMM_LINE(ecl), .SAFE_GO(safe_go), .THR_CMD(thr_cmd), .THR_RD_DATA(thr_rd),
    .MODE(mode), .DV_COUNT(dv), .INCIDENTS(inc), .ORDER_ERR(order_err),
    .RANGE_ERR(range_err), .ARM_EN(arm_en), .ARM_EN_N(arm_en_n));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ---------------------------------------------------------------
  // Pulse tally and hang guard
  // ---------------------------------------------------------------
  always @(posedge mclk) begin
    cyc++;
    if (order_err === 1'b1) n_ord++;
    if (range_err === 1'b1) n_rng++;
    if (adc_start === 1'b1) n_start++;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("checks=%0d errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic thr_acc(input logic key, input logic wr, input logic [2:0] idx,
                         input logic [15:0] data);
    if (key) begin
      thr_cmd = '{key: 1'b1, we: 1'b0, rd: 1'b0, idx: 3'h0, data: THR_KEY};
      step(1);
    end
    thr_cmd = '{key: 1'b0, we: wr, rd: ~wr, idx: idx, data: data};
    step(1);
    thr_cmd = '0;
    step(2);
  endtask
  task automatic frame(input int cs, input int rq, input int rp, input logic [1:0] st,
                       input logic [9:0] val);
    aswm_host_i.xfer(cs, {4'(rq), 12'h000}, {4'(rp), st, val});
    step(8);
  endtask
  task automatic ordered(input logic [9:0] val);
    frame(0, (slot + 1) % SLOTS, slot, ST_OK, val);
    slot = (slot + 1) % SLOTS;
    dv_exp++;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk("mode", 16'(M_START), 16'(mode));
    chk("arm_en", 16'h0000, 16'(arm_en));
    chk("arm_en_n", 16'h0001, 16'(arm_en_n));
    chk("dv", 16'h0000, dv);
    step(18);
    chk("mode", 16'(M_DIAG), 16'(mode));
    $display("reset test done");
  endtask
  task automatic t_thr();
    for (int i = 0; i <= SLOTS; i++) thr_acc(1'b1, 1'b1, 3'(i), 16'h0100 + 16'(i));
    thr_acc(1'b0, 1'b1, 3'h2, 16'h03AA);
    thr_acc(1'b1, 1'b0, 3'h2, 16'h0000);
    chk("thr_rd", 16'h0102, 16'(thr_rd));
    $display("threshold test done");
  endtask
  task automatic t_analog();
    sync_pulse = 1'b1;
    step(6);
    chk("adc_starts", 16'h0001, 16'(n_start));
    sync_pulse = 1'b0;
    adc_data = 10'h155;
    adc_done = 1'b1;
    step(1);
    adc_done = 1'b0;
    step(3);
    dv_exp++;
    chk("ana_data", 16'h0155, 16'(ana_data));
    chk("dv", 16'(dv_exp), dv);
    inhibit = 1'b1;
    step(3);
    adc_data = 10'h2AA;
    adc_done = 1'b1;
    step(1);
    adc_done = 1'b0;
    step(3);
    chk("ana_data", 16'h0155, 16'(ana_data));
    inhibit = 1'b0;
    step(3);
    $display("analog test done");
  endtask
  task automatic t_frames();
    frame(0, 0, 0, 2'h0, 10'h100);
    chk("range_errs", 16'h0001, 16'(n_rng));
    ordered(10'h100);
    ordered(10'h3EF);
    chk("dv", 16'(dv_exp), dv);
    chk("order_errs", 16'h0000, 16'(n_ord));
    frame(0, slot, (slot + 2) % SLOTS, ST_OK, 10'h100);
    dv_exp++;
    chk("order_errs", 16'h0001, 16'(n_ord));
    frame(0, slot, slot, ST_OK, VAL_MIN - 10'h001);
    chk("range_errs", 16'h0002, 16'(n_rng));
    ordered(10'h120);
    chk("dv", 16'(dv_exp), dv);
    chk("order_errs", 16'h0001, 16'(n_ord));
    for (int c = 1; c < NUM_CS; c++) frame(c, slot, (slot + 2) % SLOTS, ST_OK, 10'h100);
    dv_exp += NUM_CS - 1;
    chk("dv", 16'(dv_exp), dv);
    chk("order_errs", 16'h0004, 16'(n_ord));
    $display("frame test done");
  endtask
  task automatic t_arm();
    safe_go = 1'b1;
    step(5);
    chk("mode", 16'(M_SAFE), 16'(mode));
    ordered(10'h050);
    chk("incidents", 16'h0000, inc);
    for (int i = 0; i < ARM_N - 1; i++) ordered(10'h200);
    chk("incidents", 16'(ARM_N - 1), inc);
    chk("arm_en", 16'h0000, 16'(arm_en));
    ordered(10'h200);
    chk("mode", 16'(M_ARM), 16'(mode));
    chk("arm_en", 16'h0001, 16'(arm_en));
    chk("arm_en_n", 16'h0000, 16'(arm_en_n));
    ecl = 1'b1;
    step(6);
    chk("mode", 16'(M_SCRAP), 16'(mode));
    chk("arm_en", 16'h0000, 16'(arm_en));
    chk("arm_en_n", 16'h0001, 16'(arm_en_n));
    step(4);
    chk("mode", 16'(M_SCRAP), 16'(mode));
    // Outside diagnostic mode a keyed write must leave the threshold alone
    thr_acc(1'b1, 1'b1, 3'h0, 16'h0055);
    thr_acc(1'b1, 1'b0, 3'h0, 16'h0000);
    chk("thr_rd", 16'h0100, 16'(thr_rd));
    $display("arming test done");
  endtask

  initial begin
    reset = 1'b1;
    sync_pulse = 1'b0;
    inhibit = 1'b0;
    adc_done = 1'b0;
    adc_data = '0;
    ecl = 1'b0;
    safe_go = 1'b0;
    thr_cmd = '0;
    step(3);
    reset = 1'b0;
    step(1);
    t_reset();
    t_thr();
    t_analog();
    t_frames();
    t_arm();
    stop_test();
  end
endmodule // tb
